// [bus_byte_lane_parity.sv]
// Byte-lane enables, write parity and read parity status of the bus.
// Assumes the bus sequencer marks cycle starts, ready and hold for us.
`timescale 1ns/1ps
`include "bus_byte_lane_parity_regs.svh"

module bus_byte_lane_parity
	import bus_parity_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Core side
	input  wire logic        cyc_start,
	input  wire logic        cyc_write,
	input  wire logic [3:0]  core_lane_en,
	input  wire logic [15:0] core_wdata,
	input  wire logic        xfer_last,
	output logic [15:0]      core_rdata,
	output logic             core_rdata_valid,
	output logic             cyc_busy,
	// Bus control
	input  wire logic        bus_ready,
	input  wire logic        bus_hold,
	// Lane enables, active low, with shared output enable
	output logic             lane_enable_upper3_n,
	output logic             lane_enable_upper2_n,
	output logic             lane_enable_lower1_n,
	output logic             lane_enable_lower0_n,
	output logic             lane_enable_oe,
	// Data lines
	input  wire logic [15:0] bus_data_lines_in,
	output logic [15:0]      bus_data_lines_out,
	output logic             bus_data_lines_oe,
	// Parity lines
	input  wire logic        parity_bit_high_byte_in,
	input  wire logic        parity_bit_low_byte_in,
	output logic             parity_bit_high_byte_out,
	output logic             parity_bit_high_byte_oe,
	output logic             parity_bit_low_byte_out,
	output logic             parity_bit_low_byte_oe,
	// Parity status, active low, always driven
	output logic             parity_check_status_n
);

	bus_phase_t  phase_r;
	bus_phase_t  phase_nxt;
	logic        write_r;
	logic [3:0]  lane_en_r;
	logic [3:0]  lane_n_r;
	logic        lane_oe_r;
	logic [15:0] wdata_r;
	logic [1:0]  wpar_r;
	logic        wdrive_r;
	logic        status_n_r;
	logic [15:0] rdata_r;
	logic        rvalid_r;
	logic [1:0]  wpar_nxt;
	logic [1:0]  rd_byte_en;
	logic        rd_error;
	logic        start_ok;
	logic        xfer_done;

	// A new cycle is refused while the bus is granted away
	assign start_ok  = cyc_start && (phase_r == PHASE_IDLE) && !bus_hold;
	assign xfer_done = (phase_r == PHASE_DATA) && bus_ready;

	// Bytes of the 16-bit bus that are live for a read transfer
	assign rd_byte_en[0] = lane_en_r[`LANE_LOWER0] |
		lane_en_r[`LANE_UPPER2];
	assign rd_byte_en[1] = lane_en_r[`LANE_LOWER1] |
		lane_en_r[`LANE_UPPER3];

	// Parity of the next write word, taken from core data
	lane_parity_gen u_wpar (
		.data   (core_wdata),
		.parity (wpar_nxt)
	);

	// Check of the word on the bus against its returned parity
	read_parity_check u_rchk (
		.data_in   (bus_data_lines_in),
		.parity_in ({parity_bit_high_byte_in, parity_bit_low_byte_in}),
		.byte_en   (rd_byte_en),
		.error     (rd_error)
	);

	// Phase sequence: first clock, then data clocks until the last ready
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PHASE_IDLE: begin
				if (start_ok)
					phase_nxt = PHASE_FIRST;
			end
			PHASE_FIRST: begin
				phase_nxt = PHASE_DATA;
			end
			PHASE_DATA: begin
				if (bus_ready && xfer_last)
					phase_nxt = PHASE_IDLE;
			end
			default: begin
				phase_nxt = PHASE_IDLE;
			end
		endcase
	end

	// Phase register
	always_ff @(posedge core_clk) begin
		if (rst)
			phase_r <= PHASE_IDLE;
		else
			phase_r <= phase_nxt;
	end

	// Direction of the running cycle
	always_ff @(posedge core_clk) begin
		if (rst)
			write_r <= 1'b0;
		else if (start_ok)
			write_r <= cyc_write;
	end

	// Lane enables: loaded at start and for each further burst transfer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lane_en_r <= 4'h0;
			lane_n_r  <= `LANE_IDLE_N;
		end else if (start_ok || (xfer_done && !xfer_last)) begin
			lane_en_r <= core_lane_en;
			lane_n_r  <= ~core_lane_en;
		end else if (phase_nxt == PHASE_IDLE) begin
			lane_en_r <= 4'h0;
			lane_n_r  <= `LANE_IDLE_N;
		end
	end

	// Lane enables float while another master owns the bus
	always_ff @(posedge core_clk) begin
		if (rst)
			lane_oe_r <= 1'b0;
		else
			lane_oe_r <= !bus_hold;
	end

	// Write word and its parity, held with the same timing
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wdata_r <= `DATA_RESET;
			wpar_r  <= `PARITY_RESET;
		end else if (start_ok || (xfer_done && !xfer_last)) begin
			wdata_r <= core_wdata;
			wpar_r  <= wpar_nxt;
		end
	end

	// Data and parity drive from the second clock of a write to its end
	always_ff @(posedge core_clk) begin
		if (rst)
			wdrive_r <= 1'b0;
		else if (phase_r == PHASE_FIRST)
			wdrive_r <= write_r;
		else if (phase_nxt == PHASE_IDLE)
			wdrive_r <= 1'b0;
	end

	// Status answers in the clock after a read ready, high otherwise
	always_ff @(posedge core_clk) begin
		if (rst)
			status_n_r <= `STATUS_OK_N;
		else if (xfer_done && !write_r)
			status_n_r <= !rd_error;
		else
			status_n_r <= `STATUS_OK_N;
	end

	// Read data to the core; parity plays no part in it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r  <= `DATA_RESET;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= xfer_done && !write_r;
			if (xfer_done && !write_r)
				rdata_r <= bus_data_lines_in;
		end
	end

	// Pin and core outputs straight from flops; cyc_busy decoded from phase_r
	assign lane_enable_upper3_n     = lane_n_r[`LANE_UPPER3];
	assign lane_enable_upper2_n     = lane_n_r[`LANE_UPPER2];
	assign lane_enable_lower1_n     = lane_n_r[`LANE_LOWER1];
	assign lane_enable_lower0_n     = lane_n_r[`LANE_LOWER0];
	assign lane_enable_oe           = lane_oe_r;
	assign bus_data_lines_out       = wdata_r;
	assign bus_data_lines_oe        = wdrive_r;
	assign parity_bit_high_byte_out = wpar_r[1];
	assign parity_bit_low_byte_out  = wpar_r[0];
	assign parity_bit_high_byte_oe  = wdrive_r;
	assign parity_bit_low_byte_oe   = wdrive_r;
	assign parity_check_status_n    = status_n_r;
	assign core_rdata               = rdata_r;
	assign core_rdata_valid         = rvalid_r;
	assign cyc_busy                 = (phase_r != PHASE_IDLE) ? 1'b1 : 1'b0;

endmodule : bus_byte_lane_parity

// [bus_byte_lane_parity_regs.svh]
// Constants for the byte-lane and data parity logic of the 16-bit bus.
// Assumes one core clock; included by the design modules.
`ifndef BUS_BYTE_LANE_PARITY_REGS_SVH
`define BUS_BYTE_LANE_PARITY_REGS_SVH

// Widths
`define LANE_COUNT        4
`define BUS_WIDTH         16
`define BUS_BYTES         2
`define BYTE_WIDTH        8

// Reset and idle values
`define LANE_IDLE_N       4'hF
`define STATUS_OK_N       1'h1
`define DATA_RESET        16'h0000
`define PARITY_RESET      2'h0

// Lane enable bit positions
`define LANE_UPPER3       3
`define LANE_UPPER2       2
`define LANE_LOWER1       1
`define LANE_LOWER0       0

`endif

// [bus_parity_pkg.sv]
// Types shared by the byte-lane and data parity logic.
// Assumes nothing beyond a SystemVerilog compiler.
package bus_parity_pkg;

	// Bus cycle phase: first clock, data clocks, or idle
	typedef enum logic [1:0] {
		PHASE_IDLE,
		PHASE_FIRST,
		PHASE_DATA
	} bus_phase_t;

endpackage : bus_parity_pkg

// [lane_parity_gen.sv]
// Even-parity generator, one bit per byte of the 16-bit bus.
// Assumes purely combinational use; the caller registers the result.
`timescale 1ns/1ps
`include "bus_byte_lane_parity_regs.svh"

module lane_parity_gen
	import bus_parity_pkg::*;
(
	input  wire logic [15:0] data,
	output logic      [1:0]  parity
);

	// Parity bit makes the byte plus parity hold an even count of ones
	genvar g;
	generate
		for (g = 0; g < `BUS_BYTES; g = g + 1) begin : g_byte
			assign parity[g] = ^data[g*`BYTE_WIDTH +: `BYTE_WIDTH];
		end
	endgenerate

endmodule : lane_parity_gen

// [read_parity_check.sv]
// Read parity checker: flags a mismatch on enabled bytes only.
// Assumes bus inputs are synchronous and sampled by the caller.
`timescale 1ns/1ps
`include "bus_byte_lane_parity_regs.svh"

module read_parity_check
	import bus_parity_pkg::*;
(
	input  wire logic [15:0] data_in,
	input  wire logic [1:0]  parity_in,
	input  wire logic [1:0]  byte_en,
	output logic             error
);

	logic [1:0] expect_par;

	// Expected even parity of each received byte
	lane_parity_gen u_gen (
		.data   (data_in),
		.parity (expect_par)
	);

	// Disabled bytes never raise an error
	assign error = |((expect_par ^ parity_in) & byte_en);

endmodule : read_parity_check

// [bus_parity_chk_assertions.sv]
// Checker of lane enables, write parity and read status.
// Assumes it is bound into the top design module.
`timescale 1ns/1ps
module bus_parity_chk (
	input wire logic core_clk, rst, cyc_busy, bus_ready, bus_hold,
	input wire logic core_rdata_valid, bus_data_lines_oe, lane_enable_oe,
	input wire logic lane_enable_upper3_n, lane_enable_upper2_n,
	input wire logic lane_enable_lower1_n, lane_enable_lower0_n,
	input wire logic parity_bit_high_byte_in, parity_bit_low_byte_in,
	input wire logic parity_bit_high_byte_out, parity_bit_low_byte_out,
	input wire logic parity_bit_high_byte_oe, parity_bit_low_byte_oe,
	input wire logic parity_check_status_n,
	input wire logic [15:0] core_rdata, bus_data_lines_in, bus_data_lines_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic rd_bad;
	// A byte fault counts only where a lane of its pair is enabled
	assign rd_bad = (!(lane_enable_lower0_n & lane_enable_upper2_n)
		& ^{bus_data_lines_in[7:0], parity_bit_low_byte_in})
		| (!(lane_enable_lower1_n & lane_enable_upper3_n)
		& ^{bus_data_lines_in[15:8], parity_bit_high_byte_in});
	// Ready taken in a data clock of a read
	sequence s_rd;
		cyc_busy && $past(cyc_busy) && !bus_data_lines_oe && bus_ready;
	endsequence
	AST_RD_STATUS: assert property (s_rd |=> core_rdata_valid
		&& parity_check_status_n == !$past(rd_bad)) else $error("bad status");
	AST_RD_DATA: assert property (s_rd |=>
		core_rdata == $past(bus_data_lines_in)) else $error("bad rdata");
	AST_ST_IDLE: assert property (!core_rdata_valid |->
		parity_check_status_n) else $error("status low when idle");
	AST_HOLD_FLOAT: assert property (bus_hold |=> !lane_enable_oe)
		else $error("lanes driven in hold");
	AST_LANES_IDLE: assert property (!cyc_busy |-> &{lane_enable_upper3_n,
		lane_enable_upper2_n, lane_enable_lower1_n, lane_enable_lower0_n})
		else $error("lanes active when idle");
	AST_FIRST_QUIET: assert property ($rose(cyc_busy) |->
		!bus_data_lines_oe ##1 cyc_busy) else $error("data in first clock");
	AST_DATA_OE: assert property (bus_data_lines_oe |-> cyc_busy
		&& $past(cyc_busy)) else $error("data driven outside cycle");
	AST_PAR_OE: assert property (parity_bit_high_byte_oe == bus_data_lines_oe
		&& parity_bit_low_byte_oe == bus_data_lines_oe) else $error("par oe");
	AST_PAR_VAL: assert property (bus_data_lines_oe |->
		parity_bit_low_byte_out == ^bus_data_lines_out[7:0]
		&& parity_bit_high_byte_out == ^bus_data_lines_out[15:8])
		else $error("write parity wrong");
endmodule : bus_parity_chk
bind bus_byte_lane_parity bus_parity_chk u_chk (.*);

// [ext_mem_model.sv]
// External memory answering bus cycles after a chosen wait.
// Assumes active lanes mark a running cycle; parity pins pulled up.
`timescale 1ns/1ps
module ext_mem_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  lanes_n,
	input  wire logic [1:0]  dly,
	input  wire logic [1:0]  bad,
	input  wire logic [15:0] word,
	output logic             bus_ready,
	output logic             xfer_last,
	output logic [15:0]      data_in,
	output logic             par_hi,
	output logic             par_lo
);
	logic [2:0] cnt_r;
	// Clocks spent in the running cycle; any active lane counts as live
	// Lane values are not relied on to size the transfer
	always_ff @(posedge core_clk) begin
		if (rst || &lanes_n || bus_ready) cnt_r <= 3'h0;
		else cnt_r <= cnt_r + 3'h1;
	end
	// Single transfer, ready no sooner than the second clock
	assign bus_ready = !(&lanes_n) && cnt_r == {1'b0, dly} + 3'h1;
	assign xfer_last = bus_ready;
	// Even parity with the data, spoilt on command; released otherwise
	assign data_in = bus_ready ? word : ~word;
	assign par_lo = bus_ready ? ^word[7:0] ^ bad[0] : 1'h1;
	assign par_hi = bus_ready ? ^word[15:8] ^ bad[1] : 1'h1;
endmodule : ext_mem_model

// [bus_byte_lane_parity_tb_top.sv]
// Self-checking bench of the lane enable and parity block.
// Assumes the memory model and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module bus_byte_lane_parity_tb_top;
	logic core_clk, rst, cyc_start, cyc_write, xfer_last, bus_ready, bus_hold;
	logic core_rdata_valid, cyc_busy, oe, pi_hi, pi_lo, po_hi, po_lo, st_n;
	logic [15:0] core_wdata, core_rdata, d_in, d_out, word;
	logic [3:0] core_lane_en, ln, seen_ln;
	logic loe;
	logic [1:0] dly, bad;
	logic [21:0] note_q[$];
	int err_count = 0, cmp_count = 0;
	bus_byte_lane_parity dut (.core_clk(core_clk), .rst(rst),
		.cyc_start(cyc_start), .cyc_write(cyc_write), .xfer_last(xfer_last),
		.core_lane_en(core_lane_en), .core_wdata(core_wdata),
		.core_rdata(core_rdata), .core_rdata_valid(core_rdata_valid),
		.cyc_busy(cyc_busy), .bus_ready(bus_ready), .bus_hold(bus_hold),
		.lane_enable_upper3_n(ln[3]), .lane_enable_upper2_n(ln[2]),
		.lane_enable_lower1_n(ln[1]), .lane_enable_lower0_n(ln[0]),
		.lane_enable_oe(loe), .bus_data_lines_in(d_in),
		.bus_data_lines_out(d_out), .bus_data_lines_oe(oe),
		.parity_bit_high_byte_in(pi_hi), .parity_bit_low_byte_in(pi_lo),
		.parity_bit_high_byte_out(po_hi), .parity_bit_high_byte_oe(),
		.parity_bit_low_byte_out(po_lo), .parity_bit_low_byte_oe(),
		.parity_check_status_n(st_n));
	ext_mem_model mem (.core_clk(core_clk), .rst(rst), .lanes_n(ln),
		.dly(dly), .bad(bad), .word(word), .bus_ready(bus_ready),
		.xfer_last(xfer_last), .data_in(d_in), .par_hi(pi_hi), .par_lo(pi_lo));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Compare each transfer result with the oldest note
	always @(negedge core_clk) begin
		if (cyc_busy) seen_ln = ln;
		if (core_rdata_valid || (oe && bus_ready))
			`CHK({seen_ln, core_rdata_valid ? {core_rdata, 1'b1, st_n} : {d_out, po_hi, po_lo}}, note_q.pop_front())
	end
	// One single-transfer cycle, noting what should come back
	task automatic xfer(input logic w, input logic [3:0] en,
		input logic [15:0] v, input logic [1:0] b, dl);
		int n;
		@(negedge core_clk);
		{cyc_start, cyc_write, core_lane_en, core_wdata} = {1'b1, w, en, v};
		{word, bad, dly} = {v, b, dl};
		note_q.push_back({~en, w ? {v, ^v[15:8], ^v[7:0]} : {v, 1'b1,
			!(((en[0] | en[2]) & b[0]) | ((en[1] | en[3]) & b[1]))}});
		@(negedge core_clk);
		cyc_start = 1'b0;
		n = 0;
		while (cyc_busy && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 20) err_count++; // Cycle never ended
	endtask : xfer
	task automatic close_out();
		if (err_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	initial begin
		{cyc_start, cyc_write, bus_hold, core_lane_en, core_wdata} = '0;
		{word, bad, dly} = '0;
		rst = 1'b1;
		void'($urandom(32'hC44460E2));
		repeat (4) @(posedge core_clk);
		@(negedge core_clk) rst = 1'b0;
		// Fault on a disabled byte, then on an enabled one
		xfer(1'b0, 4'h5, 16'hA5C3, 2'h2, 2'h0);
		xfer(1'b0, 4'hA, 16'h00FF, 2'h2, 2'h3);
		xfer(1'b1, 4'hF, 16'hFFFF, 2'h0, 2'h0);
		// Bus granted away: start refused
		@(negedge core_clk) {bus_hold, cyc_start} = 2'h3;
		@(negedge core_clk) cyc_start = 1'b0;
		`CHK(cyc_busy, 1'b0)
		`CHK(loe, 1'b0)
		bus_hold = 1'b0;
		@(negedge core_clk);
		@(negedge core_clk);
		`CHK(loe, 1'b1)
		repeat (60) xfer(1'($urandom), 4'($urandom_range(15, 1)),
			16'($urandom), 2'($urandom), 2'($urandom));
		repeat (3) @(negedge core_clk);
		`CHK(note_q.size(), 0)
		close_out();
	end
	initial begin
		#20000;
		err_count++;
		close_out();
	end
endmodule : bus_byte_lane_parity_tb_top
